// ### pkg/pwr_pkg.sv
// Constants, codes and state types shared by the wiper command logic
package pwr_pkg;
    localparam int POS_W = 7;
    localparam int TAPS = 128;
    localparam logic [POS_W-1:0] MID_POS = 7'h40;
    localparam logic [POS_W-1:0] MAX_POS = 7'h7f;
    localparam logic [POS_W-1:0] MIN_POS = 7'h00;
    localparam logic [POS_W-1:0] NV_INIT = 7'h40;
    localparam logic [TAPS-1:0] TAP_ONE = {{(TAPS-1){1'b0}}, 1'b1};
    // Normal device type code; the value is arbitrary
    localparam logic [4:0] TYPE_NORMAL = 5'h0c;
    localparam logic [4:0] TYPE_INC = 5'h0b;
    localparam logic [7:0] REG_POS = 8'h00;
    localparam logic [7:0] REG_SELECT = 8'h02;
    localparam logic [7:0] SEL_WIPER = 8'h80;
    localparam logic [7:0] SEL_STORED = 8'h00;
    localparam logic SEL_RESET = 1'b1;
    localparam int TYPE_LSB = 3;
    localparam int STRAP_LSB = 1;
    localparam int RW_BIT = 0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] KIND_NONE = 2'h0;
    localparam logic [1:0] KIND_SELECT = 2'h1;
    localparam logic [1:0] KIND_POS = 2'h2;
    localparam logic [1:0] KIND_INC = 2'h3;
    localparam logic [1:0] HI_MIN = 2'h2;
    localparam int CLK_HZ = 25_000_000;
    localparam int NV_STORE_MS = 5;
    localparam int NV_STORE_CYC = NV_STORE_MS * (CLK_HZ / 1000);
    typedef enum logic [1:0] {
        PWR_BOOT, PWR_RECALL, PWR_RUN
    } pwr_boot_e;
    typedef enum logic [3:0] {
        L_IDLE, L_ADDR, L_ADDR_ACK, L_REG, L_REG_ACK, L_DATA,
        L_DATA_ACK, L_INC, L_TX, L_TX_ACK, L_IGNORE
    } pwr_link_e;
endpackage

// ### rtl/pwr_sync.sv
// Three-stage synchroniser that passes a bit once two stages agree
`timescale 1ns/1ps
`default_nettype none
module pwr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_reg <= RST;
            s2_reg <= RST;
            s3_reg <= RST;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Each bit moves on only when the two later stages agree
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= RST;
        end else begin
            q <= (s2_reg & ~(s2_reg ^ s3_reg)) | (q & (s2_reg ^ s3_reg));
        end
    end
endmodule
`default_nettype wire

// ### rtl/pwr_top.sv
// Serial command logic for the 128-step wiper and its stored copy
`timescale 1ns/1ps
`default_nettype none
module pwr_top #(
    parameter int NV_CYC = pwr_pkg::NV_STORE_CYC
) (
    // System clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Serial bus; the clock pin also clocks the link logic
    input wire logic scl_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Address strap pins
    input wire logic pin_addr_bit1,
    input wire logic pin_addr_bit0,
    // Tap select and status
    output logic [pwr_pkg::TAPS-1:0] tap_sel,
    output logic [pwr_pkg::POS_W-1:0] wiper_pos,
    output logic nv_busy
);
    localparam int CW = $clog2(NV_CYC + 1);

    // System domain state
    pwr_pkg::pwr_boot_e boot_reg;
    logic [pwr_pkg::POS_W-1:0] wiper_position_reg;
    logic [pwr_pkg::POS_W-1:0] stored_position_reg;
    logic access_select_reg;
    logic nv_busy_reg;
    logic [CW-1:0] nv_cnt_reg;
    logic last_seq_reg;
    logic stop_tgl_reg;
    logic stop_prev_reg;
    logic stop_q;
    logic [17:0] res_q;
    logic stop_det;
    logic act_ok;
    logic res_seq_q;
    logic [1:0] res_kind_q;
    logic [7:0] res_data_q;
    logic [pwr_pkg::POS_W-1:0] res_pos_q;
    logic [pwr_pkg::POS_W-1:0] res_step_q;

    // Link domain state
    pwr_pkg::pwr_link_e state_reg;
    logic [2:0] cnt_reg;
    logic [6:0] shift_reg;
    logic sda_hi_reg;
    logic is_inc_reg;
    logic is_rd_reg;
    logic reg_pos_reg;
    logic [7:0] tx_reg;
    logic [pwr_pkg::POS_W-1:0] link_wiper_reg;
    logic [1:0] res_kind_reg;
    logic [7:0] res_data_reg;
    logic res_seq_reg;
    logic [17:0] lk_q;
    logic lk_busy;
    logic lk_sel;
    logic [pwr_pkg::POS_W-1:0] lk_stored;
    logic [pwr_pkg::POS_W-1:0] lk_wiper;
    logic [1:0] lk_strap;
    logic start;
    logic [7:0] rx_byte;
    logic [4:0] rx_type;
    logic addr_ok;
    logic reg_ok;
    logic [7:0] tx_load;

    // Stop marker: data rises while the bus clock is high
    always_ff @(posedge sda_in or negedge rstn) begin
        if (!rstn) begin
            stop_tgl_reg <= 1'b0;
        end else if (scl_clk) begin
            stop_tgl_reg <= !stop_tgl_reg;
        end
    end

    // The bus clock is too fast to sample here without aliasing, so only
    // the stop marker and, below, the link result word cross into the system domain
    pwr_sync #(.W(1), .RST(1'b0)) u_pin_sync (
        .clk(clk),
        .rstn(rstn),
        .d(stop_tgl_reg),
        .q(stop_q)
    );

    // Link result word, steady once the bus clock stops
    pwr_sync #(.W(18), .RST(18'h00000)) u_res_sync (
        .clk(clk),
        .rstn(rstn),
        .d({res_seq_reg, res_kind_reg, res_data_reg, link_wiper_reg}),
        .q(res_q)
    );

    assign res_seq_q = res_q[17];
    assign res_kind_q = res_q[16:15];
    assign res_data_q = res_q[14:7];
    assign res_pos_q = res_q[13:7];
    assign res_step_q = res_q[6:0];

    // Stop seen as a change of the synchronised marker
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stop_prev_reg <= 1'b0;
        end else begin
            stop_prev_reg <= stop_q;
        end
    end

    assign stop_det = stop_q != stop_prev_reg;
    // A stop during a store is swallowed, never acted on later
    assign act_ok = stop_det && (res_seq_q != last_seq_reg) &&
        !nv_busy_reg && (boot_reg == pwr_pkg::PWR_RUN);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            last_seq_reg <= 1'b0;
        end else if (stop_det) begin
            last_seq_reg <= res_seq_q;
        end
    end

    // Power-up: mid-scale, then recall of the stored position
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            boot_reg <= pwr_pkg::PWR_BOOT;
        end else begin
            case (boot_reg)
                pwr_pkg::PWR_BOOT: boot_reg <= pwr_pkg::PWR_RECALL;
                pwr_pkg::PWR_RECALL: boot_reg <= pwr_pkg::PWR_RUN;
                pwr_pkg::PWR_RUN: boot_reg <= pwr_pkg::PWR_RUN;
                default: boot_reg <= pwr_pkg::PWR_BOOT;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wiper_position_reg <= pwr_pkg::MID_POS;
        end else if (boot_reg == pwr_pkg::PWR_RECALL) begin
            wiper_position_reg <= stored_position_reg;
        end else if (act_ok) begin
            case (res_kind_q)
                pwr_pkg::KIND_POS: wiper_position_reg <= res_pos_q;
                pwr_pkg::KIND_INC: wiper_position_reg <= res_step_q;
                default: wiper_position_reg <= wiper_position_reg;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stored_position_reg <= pwr_pkg::NV_INIT;
        end else if (act_ok && res_kind_q == pwr_pkg::KIND_POS &&
                     !access_select_reg) begin
            stored_position_reg <= res_pos_q;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            access_select_reg <= pwr_pkg::SEL_RESET;
        end else if (act_ok && res_kind_q == pwr_pkg::KIND_SELECT) begin
            if (res_data_q == pwr_pkg::SEL_WIPER) begin
                access_select_reg <= 1'b1;
            end else if (res_data_q == pwr_pkg::SEL_STORED) begin
                access_select_reg <= 1'b0;
            end
        end
    end

    // Nonvolatile store timer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            nv_busy_reg <= 1'b0;
            nv_cnt_reg <= '0;
        end else if (act_ok && res_kind_q == pwr_pkg::KIND_POS &&
                     !access_select_reg) begin
            nv_busy_reg <= 1'b1;
            nv_cnt_reg <= CW'(NV_CYC - 1);
        end else if (nv_busy_reg) begin
            if (nv_cnt_reg == '0) begin
                nv_busy_reg <= 1'b0;
            end else begin
                nv_cnt_reg <= nv_cnt_reg - CW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tap_sel <= pwr_pkg::TAP_ONE << pwr_pkg::MID_POS;
        end else begin
            tap_sel <= pwr_pkg::TAP_ONE << wiper_position_reg;
        end
    end

    assign wiper_pos = wiper_position_reg;
    assign nv_busy = nv_busy_reg;
    assign sda_out = 1'b0;

    // System state into the link domain, steady while the bus is used
    pwr_sync #(.W(18), .RST(18'h00000)) u_lk_sync (
        .clk(scl_clk),
        .rstn(rstn),
        .d({pin_addr_bit1, pin_addr_bit0, nv_busy_reg, access_select_reg,
            stored_position_reg, wiper_position_reg}),
        .q(lk_q)
    );

    assign lk_strap = lk_q[17:16];
    assign lk_busy = lk_q[15];
    assign lk_sel = lk_q[14];
    assign lk_stored = lk_q[13:7];
    assign lk_wiper = lk_q[6:0];

    always_ff @(posedge scl_clk or negedge rstn) begin
        if (!rstn) begin
            sda_hi_reg <= 1'b1;
        end else begin
            sda_hi_reg <= sda_in;
        end
    end

    assign start = sda_hi_reg && !sda_in;
    assign rx_byte = {shift_reg, sda_hi_reg};
    assign rx_type = rx_byte[7:pwr_pkg::TYPE_LSB];
    assign addr_ok = (rx_type == pwr_pkg::TYPE_NORMAL ||
        (rx_type == pwr_pkg::TYPE_INC && !rx_byte[pwr_pkg::RW_BIT])) &&
        rx_byte[pwr_pkg::STRAP_LSB+1:pwr_pkg::STRAP_LSB] == lk_strap &&
        !lk_busy;
    assign reg_ok = rx_byte == pwr_pkg::REG_POS ||
        (!is_inc_reg && rx_byte == pwr_pkg::REG_SELECT);
    assign tx_load = {1'b0, lk_sel ? lk_wiper : lk_stored};

    // Byte framing, advanced on each falling bus clock
    always_ff @(negedge scl_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= pwr_pkg::L_IDLE;
            cnt_reg <= 3'h0;
            shift_reg <= 7'h00;
            is_inc_reg <= 1'b0;
            is_rd_reg <= 1'b0;
            reg_pos_reg <= 1'b0;
        end else if (start) begin
            state_reg <= pwr_pkg::L_ADDR;
            cnt_reg <= 3'h0;
        end else if (lk_busy) begin
            state_reg <= pwr_pkg::L_IGNORE;
        end else begin
            shift_reg <= rx_byte[6:0];
            cnt_reg <= cnt_reg + 3'h1;
            case (state_reg)
                pwr_pkg::L_ADDR: begin
                    if (cnt_reg == pwr_pkg::BIT_LAST) begin
                        is_inc_reg <= rx_type == pwr_pkg::TYPE_INC;
                        is_rd_reg <= rx_byte[pwr_pkg::RW_BIT];
                        state_reg <= addr_ok ? pwr_pkg::L_ADDR_ACK :
                            pwr_pkg::L_IGNORE;
                    end
                end
                pwr_pkg::L_ADDR_ACK: begin
                    cnt_reg <= 3'h0;
                    state_reg <= is_rd_reg ? pwr_pkg::L_TX : pwr_pkg::L_REG;
                end
                pwr_pkg::L_REG: begin
                    if (cnt_reg == pwr_pkg::BIT_LAST) begin
                        reg_pos_reg <= rx_byte == pwr_pkg::REG_POS;
                        state_reg <= reg_ok ? pwr_pkg::L_REG_ACK :
                            pwr_pkg::L_IGNORE;
                    end
                end
                pwr_pkg::L_REG_ACK: begin
                    cnt_reg <= 3'h0;
                    state_reg <= is_inc_reg ? pwr_pkg::L_INC :
                        pwr_pkg::L_DATA;
                end
                pwr_pkg::L_DATA: begin
                    if (cnt_reg == pwr_pkg::BIT_LAST) begin
                        state_reg <= pwr_pkg::L_DATA_ACK;
                    end
                end
                pwr_pkg::L_DATA_ACK: state_reg <= pwr_pkg::L_IGNORE;
                pwr_pkg::L_TX: begin
                    if (cnt_reg == pwr_pkg::BIT_LAST) begin
                        state_reg <= pwr_pkg::L_TX_ACK;
                    end
                end
                pwr_pkg::L_TX_ACK: begin
                    cnt_reg <= 3'h0;
                    state_reg <= sda_hi_reg ? pwr_pkg::L_IGNORE :
                        pwr_pkg::L_TX;
                end
                default: state_reg <= state_reg;
            endcase
        end
    end

    // Data pin drive: acks and read bits, changed on falling edges
    always_ff @(negedge scl_clk or negedge rstn) begin
        if (!rstn) begin
            sda_oe <= 1'b0;
            tx_reg <= 8'h00;
        end else if (start || lk_busy) begin
            sda_oe <= 1'b0;
        end else begin
            case (state_reg)
                pwr_pkg::L_ADDR: begin
                    sda_oe <= cnt_reg == pwr_pkg::BIT_LAST && addr_ok;
                end
                pwr_pkg::L_REG: begin
                    sda_oe <= cnt_reg == pwr_pkg::BIT_LAST && reg_ok;
                end
                pwr_pkg::L_DATA: sda_oe <= cnt_reg == pwr_pkg::BIT_LAST;
                pwr_pkg::L_ADDR_ACK: begin
                    tx_reg <= tx_load;
                    sda_oe <= is_rd_reg && !tx_load[7];
                end
                pwr_pkg::L_TX: begin
                    tx_reg <= {tx_reg[6:0], 1'b0};
                    sda_oe <= cnt_reg != pwr_pkg::BIT_LAST && !tx_reg[6];
                end
                pwr_pkg::L_TX_ACK: begin
                    tx_reg <= tx_load;
                    sda_oe <= !sda_hi_reg && !tx_load[7];
                end
                default: sda_oe <= 1'b0;
            endcase
        end
    end

    // Step mode position
    always_ff @(negedge scl_clk or negedge rstn) begin
        if (!rstn) begin
            link_wiper_reg <= pwr_pkg::MID_POS;
        end else if (!start && !lk_busy) begin
            if (state_reg == pwr_pkg::L_REG_ACK && is_inc_reg) begin
                link_wiper_reg <= lk_wiper;
            end else if (state_reg == pwr_pkg::L_INC) begin
                if (sda_hi_reg && link_wiper_reg != pwr_pkg::MAX_POS) begin
                    link_wiper_reg <= link_wiper_reg + 7'h01;
                end else if (!sda_hi_reg &&
                             link_wiper_reg != pwr_pkg::MIN_POS) begin
                    link_wiper_reg <= link_wiper_reg - 7'h01;
                end
            end
        end
    end

    // Result of the frame, taken over by the system domain at stop
    always_ff @(negedge scl_clk or negedge rstn) begin
        if (!rstn) begin
            res_kind_reg <= pwr_pkg::KIND_NONE;
            res_data_reg <= 8'h00;
            res_seq_reg <= 1'b0;
        end else if (start) begin
            res_kind_reg <= pwr_pkg::KIND_NONE;
            res_seq_reg <= !res_seq_reg;
        end else if (!lk_busy && cnt_reg == pwr_pkg::BIT_LAST) begin
            if (state_reg == pwr_pkg::L_DATA) begin
                res_data_reg <= rx_byte;
                res_kind_reg <= reg_pos_reg ? pwr_pkg::KIND_POS :
                    pwr_pkg::KIND_SELECT;
            end else if (state_reg == pwr_pkg::L_REG && is_inc_reg &&
                         reg_ok) begin
                res_kind_reg <= pwr_pkg::KIND_INC;
            end
        end
    end

    sequence store_go_s;
        act_ok && res_kind_q == pwr_pkg::KIND_POS && !access_select_reg;
    endsequence

    sequence addr_hit_s;
        state_reg == pwr_pkg::L_ADDR && cnt_reg == pwr_pkg::BIT_LAST &&
            addr_ok && !start;
    endsequence

    mid_scale_a: assert property (@(posedge clk) disable iff (!rstn)
        boot_reg == pwr_pkg::PWR_BOOT |->
            wiper_position_reg == pwr_pkg::MID_POS)
        else $error("wiper not at mid-scale before recall");

    recall_load_a: assert property (@(posedge clk) disable iff (!rstn)
        boot_reg == pwr_pkg::PWR_RECALL |=>
            wiper_position_reg == $past(stored_position_reg))
        else $error("recall did not load the stored position");

    tap_follow_a: assert property (@(posedge clk) disable iff (!rstn)
        boot_reg == pwr_pkg::PWR_RUN |=> $onehot(tap_sel) &&
            tap_sel == (pwr_pkg::TAP_ONE << $past(wiper_position_reg)))
        else $error("tap select does not match the wiper");

    vol_write_a: assert property (@(posedge clk) disable iff (!rstn)
        act_ok && res_kind_q == pwr_pkg::KIND_POS && access_select_reg
        |=> wiper_position_reg == $past(res_pos_q) &&
            $stable(stored_position_reg) && !nv_busy_reg)
        else $error("wiper write touched the stored position");

    store_write_a: assert property (@(posedge clk) disable iff (!rstn)
        store_go_s |=> nv_busy_reg[*8] ##0
            stored_position_reg == wiper_position_reg)
        else $error("stored write did not update both positions");

    store_len_a: assert property (@(posedge clk) disable iff (!rstn)
        nv_busy_reg |-> nv_cnt_reg <= CW'(NV_CYC - 1))
        else $error("store timer exceeds its length");

    nv_equal_a: assert property (@(posedge clk) disable iff (!rstn)
        $fell(nv_busy_reg) |->
            stored_position_reg == wiper_position_reg)
        else $error("positions differ when the store ends");

    step_commit_a: assert property (@(posedge clk) disable iff (!rstn)
        act_ok && res_kind_q == pwr_pkg::KIND_INC |=>
            wiper_position_reg == $past(res_step_q))
        else $error("stepped position not kept at stop");

    step_up_a: assert property (@(negedge scl_clk) disable iff (!rstn)
        state_reg == pwr_pkg::L_INC && !start && !lk_busy && sda_hi_reg &&
            link_wiper_reg != pwr_pkg::MAX_POS |=>
            link_wiper_reg == $past(link_wiper_reg) + 7'h01)
        else $error("step up missed");

    sat_top_a: assert property (@(negedge scl_clk) disable iff (!rstn)
        state_reg == pwr_pkg::L_INC && sda_hi_reg &&
            link_wiper_reg == pwr_pkg::MAX_POS |=>
            link_wiper_reg == pwr_pkg::MAX_POS)
        else $error("step wrapped past maximum");

    sat_bottom_a: assert property (@(negedge scl_clk) disable iff (!rstn)
        state_reg == pwr_pkg::L_INC && !sda_hi_reg &&
            link_wiper_reg == pwr_pkg::MIN_POS |=>
            link_wiper_reg == pwr_pkg::MIN_POS)
        else $error("step wrapped past minimum");

    msb_zero_a: assert property (@(negedge scl_clk) disable iff (!rstn)
        state_reg == pwr_pkg::L_ADDR_ACK && is_rd_reg && !start &&
            !lk_busy |=> !tx_reg[7] && sda_oe)
        else $error("read data top bit not zero");

    busy_quiet_a: assert property (@(negedge scl_clk) disable iff (!rstn)
        lk_busy |=> !sda_oe)
        else $error("data pin driven during store");

    step_noack_a: assert property (@(negedge scl_clk) disable iff (!rstn)
        state_reg == pwr_pkg::L_INC |-> !sda_oe)
        else $error("data pin driven in step mode");

    addr_ack_a: assert property (@(negedge scl_clk) disable iff (!rstn)
        addr_hit_s |=> sda_oe && state_reg == pwr_pkg::L_ADDR_ACK)
        else $error("matching address not acknowledged");
endmodule
`default_nettype wire

// ### verif/pwr_master.sv
// Two-wire bus master model; the data line has a pull-up
`timescale 1ns/1ps
`default_nettype none
module pwr_master (
    // Bus lines
    output logic scl = 1'b1,
    output logic sda_drv = 1'b1,
    input wire logic sda
);
    task automatic bit_io(input logic b, output logic r);
        sda_drv = b;
        #8 scl = 1'b1;
        #7 r = sda;
        #8 scl = 1'b0;
        #7;
    endtask
    task automatic start();
        sda_drv = 1'b1;
        #8 scl = 1'b0;
        #8 scl = 1'b1;
        #7 sda_drv = 1'b0;
        #8 scl = 1'b0;
        #7;
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        #8 scl = 1'b1;
        #250 sda_drv = 1'b1;
        #250;
    endtask
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic get(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(1'b1, r);
    endtask
endmodule
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the wiper command logic
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [1:0] STRAP = 2'h2;
    localparam logic [7:0] AW = {pwr_pkg::TYPE_NORMAL, STRAP, 1'b0};
    localparam logic [7:0] AI = {pwr_pkg::TYPE_INC, STRAP, 1'b0};
    logic clk = 1'b0;
    logic rstn = 1'b1;
    logic pin_addr_bit1 = 1'b1;
    logic pin_addr_bit0 = 1'b0;
    logic scl, sda_drv, sda_oe, sda_out, nv_busy, sda_line;
    logic [6:0] wiper_pos;
    logic [pwr_pkg::TAPS-1:0] tap_sel;
    logic [7:0] exp_q[$];
    logic [7:0] got, e_w, rnd = 8'h4e;
    logic [6:0] st_p[2] = '{7'h7e, 7'h01};
    logic [6:0] st_e[2] = '{7'h7f, 7'h00};
    logic [3:0] st_b[2] = '{4'hd, 4'h2};
    int n_errors = 0;
    int checked = 0;
    event got_ev;
    assign sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);
    always #20 clk = ~clk;
    pwr_master pwr_master_inst (.scl(scl), .sda_drv(sda_drv), .sda(sda_line));
    pwr_top #(.NV_CYC(40)) pwr_top_inst (.clk(clk), .rstn(rstn),
        .scl_clk(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .pin_addr_bit1(pin_addr_bit1), .pin_addr_bit0(pin_addr_bit0),
        .tap_sel(tap_sel), .wiper_pos(wiper_pos), .nv_busy(nv_busy));
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    task automatic chk(input logic [7:0] e, input logic [7:0] v);
        exp_q.push_back(e);
        got = v;
        ->got_ev;
        #1;
    endtask
    always @(got_ev) begin
        checked++;
        e_w = exp_q.pop_front();
        if (got !== e_w) begin
            n_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, e_w);
        end
    end
    task automatic hdr(input logic [7:0] a, r, input logic ok);
        logic k;
        pwr_master_inst.start();
        pwr_master_inst.put(a, k);
        chk(8'(ok), 8'(k));
        if (ok) begin
            pwr_master_inst.put(r, k);
            chk(8'h01, 8'(k));
        end
    endtask
    task automatic wr(input logic [7:0] r, d);
        logic k;
        hdr(AW, r, 1'b1);
        pwr_master_inst.put(d, k);
        chk(8'h01, 8'(k));
        pwr_master_inst.stop();
        repeat (8) @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] e);
        logic k;
        logic [7:0] v;
        hdr(AW, pwr_pkg::REG_POS, 1'b1);
        pwr_master_inst.start();
        pwr_master_inst.put({AW[7:1], 1'b1}, k);
        chk(8'h01, 8'(k));
        pwr_master_inst.get(v);
        pwr_master_inst.stop();
        chk(e, v);
    endtask
    task automatic pos(input logic [6:0] e);
        chk({1'b0, e}, {1'b0, wiper_pos});
        chk(8'h01, 8'(tap_sel === (pwr_pkg::TAP_ONE << e)));
    endtask
    task automatic finish_test();
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        logic [7:0] d;
        logic k;
        rstn <= 1'b0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        pos(7'h40);
        wr(pwr_pkg::REG_SELECT, pwr_pkg::SEL_WIPER);
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            d = rnd | 8'h80;
            wr(pwr_pkg::REG_POS, d);
            pos(d[6:0]);
            chk(8'h00, 8'(nv_busy));
            rd({1'b0, d[6:0]});
        end
        hdr({5'h1f, STRAP, 1'b0}, 8'h00, 1'b0);
        pwr_master_inst.stop();
        hdr({pwr_pkg::TYPE_NORMAL, ~STRAP, 1'b0}, 8'h00, 1'b0);
        pwr_master_inst.stop();
        for (int i = 0; i < 2; i++) begin
            wr(pwr_pkg::REG_POS, {1'b0, st_p[i]});
            hdr(AI, pwr_pkg::REG_POS, 1'b1);
            for (int j = 3; j >= 0; j--) pwr_master_inst.bit_io(st_b[i][j], k);
            pwr_master_inst.stop();
            repeat (8) @(posedge clk);
            pos(st_e[i]);
        end
        wr(pwr_pkg::REG_SELECT, pwr_pkg::SEL_STORED);
        wr(pwr_pkg::REG_POS, 8'h95);
        chk(8'h01, 8'(nv_busy));
        pos(7'h15);
        hdr(AW, 8'h00, 1'b0);
        pwr_master_inst.stop();
        for (int i = 0; i < 100 && nv_busy !== 1'b0; i++) @(posedge clk);
        chk(8'h00, 8'(nv_busy));
        k = 1'b0;
        for (int i = 0; i < 4 && !k; i++) begin
            pwr_master_inst.start();
            pwr_master_inst.put(AW, k);
            pwr_master_inst.stop();
        end
        chk(8'h01, 8'(k));
        rd(8'h15);
        pos(7'h15);
        finish_test();
    end
    initial begin
        #200000;
        n_errors++;
        finish_test();
    end
endmodule
`default_nettype wire
